// ===== disp_result_pkg.sv
// Constants and types for the displacement result processor
// Assumes a single 200 MHz clock domain and an APB register slave
package disp_result_pkg;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFF_CONTROL   = 8'h00;
  localparam logic [7:0] OFF_COMMAND   = 8'h04;
  localparam logic [7:0] OFF_CAL_ENTRY = 8'h08;
  localparam logic [7:0] OFF_CAL_FACT  = 8'h0C;
  localparam logic [7:0] OFF_OFFSET    = 8'h10;
  localparam logic [7:0] OFF_RESULT    = 8'h14;
  localparam logic [7:0] OFF_STATUS    = 8'h18;
  localparam logic [7:0] OFF_INTENS    = 8'h1C;
  localparam logic [7:0] OFF_SPAN      = 8'h20;

  // ==========================================================
  // Command register bit positions (write one to act)
  localparam int CMD_ZERO      = 0;
  localparam int CMD_HOLD      = 1;
  localparam int CMD_CAL_START = 2;
  localparam int CMD_CAL_DONE  = 3;
  localparam int CMD_PARAM_SEL = 4;
  localparam int CMD_CONFIRM   = 5;
  localparam int CMD_OFS_START = 6;
  localparam int CMD_CAL_WRITE = 7;

  // ==========================================================
  // Control register fields and command key codes
  localparam int CTL_MODE_LSB  = 0;
  localparam int CTL_MODE_KEY  = 2;
  localparam int CTL_GAIN_LSB  = 4;
  localparam int CTL_GAIN_KEY  = 7;
  localparam int CTL_COMB_LSB  = 8;
  localparam int CTL_COMB_KEY  = 10;

  // ==========================================================
  // Calibration factor, Q2.14 fixed point, and its limits
  localparam int              CAL_FRAC      = 14;
  localparam logic [15:0]     CAL_ONE       = 16'h4000;
  localparam logic [15:0]     CAL_MIN       = 16'h399A;  // 0.9
  localparam logic [15:0]     CAL_MAX       = 16'h4666;  // 1.1
  localparam logic [31:0]     SPAN_RESET    = 32'h00027FEE;
  localparam logic [31:0]     OFFSET_RESET  = 32'h00000000;

  // ==========================================================
  // Enumerations
  typedef enum logic [1:0] {
    MODE_NORMAL, MODE_PEAK_TO_PEAK, MODE_PEAK, MODE_BOTTOM
  } meas_mode_type;

  typedef enum logic [1:0] {
    COMB_CHANNEL_ONE, COMB_CHANNEL_TWO, COMB_NEG_SUM, COMB_DIFF
  } comb_mode_type;

  typedef enum logic [1:0] {
    ENTRY_IDLE, ENTRY_CAL, ENTRY_OFFSET, ENTRY_ABORT
  } entry_type;

  // One sample from the sensor heads
  typedef struct packed {
    logic        valid;
    logic [31:0] ch1;
    logic [31:0] ch2;
    logic [15:0] int1;
    logic [15:0] int2;
  } sample_type;

  // Result towards display and output
  typedef struct packed {
    logic        valid;
    logic        overflow;
    logic [31:0] value;
    logic [15:0] intensity;
  } result_type;

endpackage

// ===== disp_result_processor.sv
// Displacement result processor: mode, gain, channel, calibration, offset
// Assumes samples arrive on the same clock; registers reached over APB
//
// Functional notes
// R01 - Normal mode outputs each sample from the reference.
// R02 - Peak-to-peak outputs maximum minus minimum since the last clear.
// R03 - Peak mode outputs largest sample since the last clear.
// R04 - Bottom mode outputs smallest sample since the last clear.
// R05 - Reselecting an active tracking mode clears extremes.
// R06 - Hold on then off also clears tracked extremes.
// R07 - Four gain levels plus automatic; level in use reported.
// R08 - Automatic gain steps by received intensity.
// R09 - Gain key in automatic freezes the current level, leaving automatic.
// R10 - One channel combination active at a time.
// R11 - Sum mode outputs the negated sum of both channels.
// R12 - Difference mode outputs channel one minus channel two.
// R13 - Combination change refused with one head.
// R14 - Sum and difference modes report channel one intensity.
// R15 - Calibration zeroes one end, scales entry over travel.
// R16 - Ratio outside 0.9 to 1.1 rejected, old factor kept, error shown.
// R17 - Parameter select, confirm abandons calibration entry.
// R18 - Calibration factor readable and directly writable.
// R19 - Signed offset added to every result.
// R20 - Result beyond span shows overflow.
// R21 - Aborting offset entry keeps the old offset.
// R22 - Zero captures current measurement as new reference.
// R23 - Extremes reload from first sample after clear.
// R24 - Reset gives normal mode, automatic gain, channel one, zero offset.
module disp_result_processor #(
  parameter int GAIN_LOW_TH  = 50,
  parameter int GAIN_HIGH_TH = 40000
) (
  // Clock and reset
  input  wire logic                        clock,
  input  wire logic                        reset_n,
  // APB slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [7:0]                  paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  // Sensor heads
  input  wire logic                        head_two_present,
  input  wire disp_result_pkg::sample_type sample,
  // Results
  output disp_result_pkg::result_type      result,
  output logic      [1:0]                  gain_level,
  output logic                             gain_auto,
  output logic                             cal_error
);

  initial begin
    if (GAIN_LOW_TH >= GAIN_HIGH_TH || GAIN_HIGH_TH > 65535) begin
      $error("gain thresholds invalid");
    end
  end

  // ==========================================================
  // Reset synchroniser and head-present synchroniser
  logic rst_meta_r, rst_sync_r, hp_meta_r, hp_sync_r;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end
  wire rst_n = rst_sync_r;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hp_meta_r <= 1'b0;
      hp_sync_r <= 1'b0;
    end else begin
      hp_meta_r <= head_two_present;
      hp_sync_r <= hp_meta_r;
    end
  end

  // ==========================================================
  // APB decode
  wire        wr_en = psel && penable && pwrite;
  wire        rd_en = psel && penable && !pwrite;
  wire        w_ctl = wr_en && paddr == disp_result_pkg::OFF_CONTROL;
  wire        w_cmd = wr_en && paddr == disp_result_pkg::OFF_COMMAND;
  wire        w_ent = wr_en && paddr == disp_result_pkg::OFF_CAL_ENTRY;
  wire        w_ofs = wr_en && paddr == disp_result_pkg::OFF_OFFSET;
  wire        w_spn = wr_en && paddr == disp_result_pkg::OFF_SPAN;
  wire [31:0] cmd   = w_cmd ? pwdata : 32'h00000000;
  wire        mapped = paddr <= disp_result_pkg::OFF_SPAN && paddr[1:0] == 2'h0;

  wire key_mode = w_ctl && pwdata[disp_result_pkg::CTL_MODE_KEY];
  wire key_gain = w_ctl && pwdata[disp_result_pkg::CTL_GAIN_KEY];
  wire key_comb = w_ctl && pwdata[disp_result_pkg::CTL_COMB_KEY];
  wire [1:0] new_mode = pwdata[disp_result_pkg::CTL_MODE_LSB +: 2];
  wire [2:0] new_gain = pwdata[disp_result_pkg::CTL_GAIN_LSB +: 3];
  wire [1:0] new_comb = pwdata[disp_result_pkg::CTL_COMB_LSB +: 2];

  // ==========================================================
  // Mode, gain, combination, hold state
  disp_result_pkg::meas_mode_type mode_r;
  disp_result_pkg::comb_mode_type comb_r;
  disp_result_pkg::entry_type     entry_r, entry_nxt;
  logic        hold_r, track_clr_r, param_armed_r;
  logic        auto_r;
  logic [1:0]  level_r, level_nxt;

  wire same_mode   = key_mode && new_mode == mode_r && mode_r != disp_result_pkg::MODE_NORMAL;
  wire hold_off    = cmd[disp_result_pkg::CMD_HOLD] && hold_r;
  wire extreme_clr = same_mode || hold_off;                                    // R05 R06

  wire [15:0] int_sel = sample.int1;
  always_comb begin
    level_nxt = level_r;
    if (auto_r && sample.valid) begin                                          // R08
      if (int_sel < 16'(GAIN_LOW_TH) && level_r != 2'h3) begin
        level_nxt = level_r + 2'h1;
      end else if (int_sel > 16'(GAIN_HIGH_TH) && level_r != 2'h0) begin
        level_nxt = level_r - 2'h1;
      end
    end
    if (key_gain) begin
      if (new_gain[2]) begin
        level_nxt = level_r;
      end else begin
        level_nxt = new_gain[1:0];                                             // R07
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mode_r  <= disp_result_pkg::MODE_NORMAL;                                 // R24
      comb_r  <= disp_result_pkg::COMB_CHANNEL_ONE;
      auto_r  <= 1'b1;
      level_r <= 2'h0;
      hold_r  <= 1'b0;
    end else begin
      if (key_mode) begin
        mode_r <= disp_result_pkg::meas_mode_type'(new_mode);
      end
      if (key_comb && hp_sync_r) begin                                         // R13
        comb_r <= disp_result_pkg::comb_mode_type'(new_comb);                  // R10
      end
      if (key_gain) begin
        auto_r <= new_gain[2] && !auto_r;                                      // R09
      end
      level_r <= level_nxt;
      if (cmd[disp_result_pkg::CMD_HOLD]) begin
        hold_r <= !hold_r;
      end
    end
  end

  // ==========================================================
  // Channel combination
  wire [31:0] sum_ch  = sample.ch1 + sample.ch2;
  wire [31:0] raw     = comb_r == disp_result_pkg::COMB_CHANNEL_ONE ? sample.ch1 :
                        comb_r == disp_result_pkg::COMB_CHANNEL_TWO ? sample.ch2 :
                        comb_r == disp_result_pkg::COMB_NEG_SUM ? 32'h00000000 - sum_ch // R11
                        : sample.ch1 - sample.ch2;                                      // R12
  wire [15:0] int_out = comb_r == disp_result_pkg::COMB_CHANNEL_TWO ? sample.int2
                        : sample.int1;                                                  // R14

  // ==========================================================
  // Calibration scaling
  logic [15:0] cal_r, cal_pend_r;
  logic [31:0] ref_r, travel_r;

  function automatic logic [31:0] scale(input logic [31:0] v, input logic [15:0] f);
    logic signed [47:0] p;
    p = $signed(v) * $signed({1'b0, f});
    return p[disp_result_pkg::CAL_FRAC +: 32];
  endfunction

  wire [31:0] scaled = scale(raw, cal_r);
  wire [31:0] rel    = scaled - ref_r;                                         // R01 R22

  // Ratio entry / measured travel in Q2.14
  wire [47:0] ent_sh   = {pwdata, 16'h0000} >> (16 - disp_result_pkg::CAL_FRAC);
  wire [31:0] trav_abs = travel_r[31] ? 32'h00000000 - travel_r : travel_r;
  wire [47:0] ratio_w  = trav_abs == 32'h0 ? 48'hFFFFFFFFFFFF : ent_sh / {16'h0, trav_abs};
  wire        ratio_ok = ratio_w >= {32'h0, disp_result_pkg::CAL_MIN} &&
                         ratio_w <= {32'h0, disp_result_pkg::CAL_MAX};       // R16
  wire [15:0] ratio    = ratio_w[15:0];
  wire [15:0] cal_new  = 16'((32'(cal_r) * 32'(ratio)) >> disp_result_pkg::CAL_FRAC);

  // ==========================================================
  // Entry sequencing for calibration and offset
  logic [31:0] offset_r, span_r;
  always_comb begin
    entry_nxt = entry_r;
    case (entry_r)
      disp_result_pkg::ENTRY_IDLE: begin
        if (cmd[disp_result_pkg::CMD_CAL_START]) begin
          entry_nxt = disp_result_pkg::ENTRY_CAL;                              // R15
        end else if (cmd[disp_result_pkg::CMD_OFS_START]) begin
          entry_nxt = disp_result_pkg::ENTRY_OFFSET;
        end
      end
      disp_result_pkg::ENTRY_CAL, disp_result_pkg::ENTRY_OFFSET: begin
        if (cmd[disp_result_pkg::CMD_PARAM_SEL]) begin
          entry_nxt = disp_result_pkg::ENTRY_ABORT;
        end else if (w_ent || w_ofs) begin
          entry_nxt = disp_result_pkg::ENTRY_IDLE;
        end
      end
      disp_result_pkg::ENTRY_ABORT: begin
        if (cmd[disp_result_pkg::CMD_CONFIRM]) begin
          entry_nxt = disp_result_pkg::ENTRY_IDLE;                             // R17 R21
        end
      end
      default: entry_nxt = disp_result_pkg::ENTRY_IDLE;
    endcase
  end

  wire cal_commit = entry_r == disp_result_pkg::ENTRY_CAL && w_ent &&
                    !cmd[disp_result_pkg::CMD_PARAM_SEL];
  wire ofs_commit = w_ofs && entry_r == disp_result_pkg::ENTRY_OFFSET;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      entry_r    <= disp_result_pkg::ENTRY_IDLE;
      cal_r      <= disp_result_pkg::CAL_ONE;
      cal_pend_r <= disp_result_pkg::CAL_ONE;
      cal_error  <= 1'b0;
      ref_r      <= 32'h00000000;
      travel_r   <= 32'h00000000;
      offset_r   <= disp_result_pkg::OFFSET_RESET;                             // R24
      span_r     <= disp_result_pkg::SPAN_RESET;
    end else begin
      entry_r <= entry_nxt;
      if (cmd[disp_result_pkg::CMD_ZERO] && sample.valid) begin
        ref_r <= scaled;                                                       // R22 R15
      end
      if (cmd[disp_result_pkg::CMD_CAL_START] && sample.valid) begin
        travel_r <= rel;                                                       // R15
      end
      if (cal_commit) begin
        cal_error <= !ratio_ok;
        if (ratio_ok) begin
          cal_r <= cal_new;                                                    // R16
        end
        cal_pend_r <= cal_new;
      end else if (cmd[disp_result_pkg::CMD_CAL_START]) begin
        cal_error <= 1'b0;
      end
      if (cmd[disp_result_pkg::CMD_CAL_WRITE]) begin
        cal_r <= pwdata[31:16];                                                // R18
      end
      if (ofs_commit) begin
        offset_r <= pwdata;                                                    // R21
      end
      if (w_spn) begin
        span_r <= pwdata;
      end
    end
  end

  // ==========================================================
  // Extreme tracking
  logic [31:0] max_r, min_r;
  logic        have_r;
  wire         lt_min = $signed(rel) < $signed(min_r);
  wire         gt_max = $signed(rel) > $signed(max_r);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      have_r <= 1'b0;
      max_r  <= 32'h00000000;
      min_r  <= 32'h00000000;
    end else if (extreme_clr || key_mode) begin
      have_r <= 1'b0;                                                          // R05 R06
    end else if (sample.valid && !hold_r) begin
      have_r <= 1'b1;
      if (!have_r || gt_max) begin
        max_r <= rel;                                                          // R23 R03
      end
      if (!have_r || lt_min) begin
        min_r <= rel;                                                          // R23 R04
      end
    end
  end

  wire [31:0] tr_max  = have_r && !gt_max ? max_r : rel;
  wire [31:0] tr_min  = have_r && !lt_min ? min_r : rel;
  wire [31:0] mode_v  = mode_r == disp_result_pkg::MODE_NORMAL ? rel :          // R01
                        mode_r == disp_result_pkg::MODE_PEAK_TO_PEAK ? tr_max - tr_min : // R02
                        mode_r == disp_result_pkg::MODE_PEAK ? tr_max : tr_min;
  wire signed [32:0] adj = 33'($signed(mode_v)) + 33'($signed(offset_r));     // R19
  wire [32:0] adj_abs    = adj[32] ? 33'h000000000 - adj : adj;
  wire        ovf        = adj_abs > {1'b0, span_r};                            // R20

  // ==========================================================
  // Result register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      result <= '0;
    end else if (sample.valid && !hold_r) begin
      result.valid     <= 1'b1;
      result.overflow  <= ovf;                                                 // R20
      result.value     <= ovf ? 32'h00000000 : adj[31:0];
      result.intensity <= int_out;
    end else begin
      result.valid <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      gain_level <= 2'h0;
      gain_auto  <= 1'b1;
    end else begin
      gain_level <= level_nxt;                                                 // R07
      gain_auto  <= key_gain ? new_gain[2] && !auto_r : auto_r;
    end
  end

  // ==========================================================
  // APB read and response
  wire [31:0] status_w = {24'h000000, cal_error, hold_r, hp_sync_r, 1'b0,
                          entry_r, level_r};
  wire [31:0] ctl_w    = {22'h0, comb_r, 1'b0, auto_r, level_r, 2'h0, mode_r};
  wire [31:0] rd_mux   = paddr == disp_result_pkg::OFF_CONTROL   ? ctl_w :
                         paddr == disp_result_pkg::OFF_CAL_ENTRY ? {16'h0000, cal_pend_r} :
                         paddr == disp_result_pkg::OFF_CAL_FACT  ? {cal_r, 16'h0000} :
                         paddr == disp_result_pkg::OFF_OFFSET    ? offset_r :
                         paddr == disp_result_pkg::OFF_RESULT    ? result.value :
                         paddr == disp_result_pkg::OFF_STATUS    ? status_w :
                         paddr == disp_result_pkg::OFF_INTENS    ? {16'h0000, result.intensity} :
                         paddr == disp_result_pkg::OFF_SPAN      ? span_r : 32'h00000000;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata  <= (psel && !penable && !pwrite) ? rd_mux : 32'h00000000;
    end
  end

endmodule

// ===== disp_result_chk.sv
// Port checker of the result processor
// Assumes a bind to it on its single clock
module disp_result_chk (
  // Clock and reset
  input wire logic                        clock,
  input wire logic                        reset_n,
  // APB
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic                        pwrite,
  input wire logic [7:0]                  paddr,
  input wire logic                        pready,
  input wire logic                        pslverr,
  // Samples and results
  input wire disp_result_pkg::sample_type sample,
  input wire disp_result_pkg::result_type result,
  input wire logic [1:0]                  gain_level,
  input wire logic                        gain_auto,
  input wire logic                        cal_error
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  // ==========================================================
  // Write decodes
  wire any_wr = psel && penable && pwrite;
  wire ctl_wr = any_wr && paddr == disp_result_pkg::OFF_CONTROL;
  // ==========================================================
  // Properties
  property p_valid_cause; result.valid |-> $past(sample.valid); endproperty
  a_valid_cause: assert property (p_valid_cause) else $error("valid without sample");
  property p_ovf_blank; result.overflow |-> result.value == 32'h0; endproperty
  a_ovf_blank: assert property (p_ovf_blank) else $error("overflow with value");
  property p_int_src;
    result.valid |-> result.intensity == $past(sample.int1) || result.intensity == $past(sample.int2);
  endproperty
  a_int_src: assert property (p_int_src) else $error("foreign intensity");
  property p_auto_kept; gain_auto && !ctl_wr |=> gain_auto; endproperty
  a_auto_kept: assert property (p_auto_kept) else $error("auto gain dropped");
  property p_fixed_hold; !gain_auto && !ctl_wr |=> !gain_auto && $stable(gain_level); endproperty
  a_fixed_hold: assert property (p_fixed_hold) else $error("fixed gain moved");
  property p_auto_step;
    gain_auto && $past(gain_auto) |-> (gain_level - $past(gain_level)) inside {2'h0, 2'h1, 2'h3};
  endproperty
  a_auto_step: assert property (p_auto_step) else $error("auto gain jumped");
  property p_ready_next; psel && !penable |=> pready; endproperty
  a_ready_next: assert property (p_ready_next) else $error("ready missing");
  property p_ready_qual; pready |-> psel && penable && !$past(pready); endproperty
  a_ready_qual: assert property (p_ready_qual) else $error("stray ready");
  property p_err_qual; pslverr |-> pready; endproperty
  a_err_qual: assert property (p_err_qual) else $error("stray error");
  property p_cal_cause; $changed(cal_error) |-> $past(any_wr); endproperty
  a_cal_cause: assert property (p_cal_cause) else $error("stray cal error");
  c_ovf: cover property (result.valid && result.overflow);
  c_cal: cover property ($rose(cal_error));
  c_gain: cover property (gain_auto && $changed(gain_level));
endmodule

bind disp_result_processor disp_result_chk u_chk (.clock(clock), .reset_n(reset_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready),
  .pslverr(pslverr), .sample(sample), .result(result), .gain_level(gain_level),
  .gain_auto(gain_auto), .cal_error(cal_error));

// ===== sensor_head_model.sv
// Model of the two sensor heads delivering one reading per send pulse
// Assumes the bench raises send for one clock per sample
module sensor_head_model (
  // Clock
  input wire logic                        clock,
  // Reading requested by the bench
  input wire logic                        send,
  input wire logic [31:0]                 ch1_v,
  input wire logic [31:0]                 ch2_v,
  input wire logic [15:0]                 int1_v,
  input wire logic [15:0]                 int2_v,
  // Sample stream
  output disp_result_pkg::sample_type     sample
);
  logic [95:0] last_r = '0;
  always_ff @(posedge clock) begin
    if (send) begin
      last_r <= {ch1_v, ch2_v, int1_v, int2_v};
    end
  end
  // Idle lines show the inverse of the last reading
  assign sample = send ? {1'h1, ch1_v, ch2_v, int1_v, int2_v} : {1'h0, ~last_r};
endmodule

// ===== tb.sv
// Self-checking bench for the displacement result processor
// Assumes the head model and the bound checker
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 1'h0, reset_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic        send = 1'h0, head2 = 1'h0, err, ro, pready, pslverr, gain_auto, cal_error;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, c1 = 32'h0, c2 = 32'h0, prdata, q, v, a, b, mx, mn;
  logic [15:0] i1 = 16'h03E8, i2 = 16'h07D0, ri;
  logic [1:0]  gain_level, la;
  int          bad_count = 0, cmp_count = 0, m, k;
  integer      seed = 32'hF896;
  disp_result_pkg::sample_type sample;
  disp_result_pkg::result_type result;

  initial forever #2.5 clock = ~clock;
  sensor_head_model u_heads (.clock(clock), .send(send), .ch1_v(c1), .ch2_v(c2),
    .int1_v(i1), .int2_v(i2), .sample(sample));
  disp_result_processor u_dut (.clock(clock), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .head_two_present(head2), .sample(sample),
    .result(result), .gain_level(gain_level), .gain_auto(gain_auto), .cal_error(cal_error));

  // ==========================================================
  // Expectations and checks
  function automatic logic [31:0] rnd();
    rnd = $random(seed) % 20000;
  endfunction
  function automatic logic [31:0] comb_exp(input int c, input logic [31:0] x, y);
    comb_exp = c == 0 ? x : c == 1 ? y : c == 2 ? -(x + y) : x - y;
  endfunction
  function automatic logic [31:0] mode_exp(input int c, input logic [31:0] x);
    mode_exp = c == 0 ? x : c == 1 ? mx - mn : c == 2 ? mx : mn;
  endfunction
  task chk_word(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task complete_run();
    $display("Comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ==========================================================
  // Bus and sample drivers
  task apb(input logic w, input logic [7:0] ad, input logic [31:0] d, input logic s);
    int n;
    @(posedge clock);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'h1;
    send <= s;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'h1 && n < 16);
    if (n >= 16) bad_count++;
    q = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    send <= 1'h0;
  endtask
  task cmd(input int bit_n, input logic s);
    apb(1'h1, disp_result_pkg::OFF_COMMAND, 32'h1 << bit_n, s);
  endtask
  task ctl(input logic [31:0] d);
    apb(1'h1, disp_result_pkg::OFF_CONTROL, d, 1'h0);
  endtask
  task rd(input logic [7:0] ad);
    apb(1'h0, ad, 32'h0, 1'h0);
  endtask
  task smp(input logic [31:0] x, input logic [31:0] y);
    int n;
    @(posedge clock);
    c1 <= x;
    c2 <= y;
    send <= 1'h1;
    @(posedge clock);
    send <= 1'h0;
    #1;
    n = 0;
    while (result.valid !== 1'h1 && n < 4) begin
      @(posedge clock);
      #1;
      n++;
    end
    chk_word("result valid", 32'h1, {31'h0, result.valid});
    v = result.value;
    ro = result.overflow;
    ri = result.intensity;
  endtask
  task step(input int c, input logic first);
    a = rnd();
    smp(a, 32'h0);
    if (first || $signed(a) > $signed(mx)) mx = a;
    if (first || $signed(a) < $signed(mn)) mn = a;
    chk_word("mode value", mode_exp(c, a), v);
  endtask
  task cal(input logic [31:0] entry, input logic abort);
    c1 <= 32'h0;
    cmd(disp_result_pkg::CMD_ZERO, 1'h1);
    c1 <= 32'h4000;
    cmd(disp_result_pkg::CMD_CAL_START, 1'h1);
    if (abort) cmd(disp_result_pkg::CMD_PARAM_SEL, 1'h0);
    apb(1'h1, disp_result_pkg::OFF_CAL_ENTRY, entry, 1'h0);
    cmd(disp_result_pkg::CMD_CONFIRM, 1'h0);
    rd(disp_result_pkg::OFF_CAL_FACT);
  endtask
  task ofs(input logic [31:0] o, input logic abort);
    cmd(disp_result_pkg::CMD_OFS_START, 1'h0);
    if (abort) cmd(disp_result_pkg::CMD_PARAM_SEL, 1'h0);
    apb(1'h1, disp_result_pkg::OFF_OFFSET, o, 1'h0);
    cmd(disp_result_pkg::CMD_CONFIRM, 1'h0);
  endtask

  // ==========================================================
  // Scenarios
  initial begin
    #100000;
    bad_count++;
    complete_run();
  end
  initial begin
    repeat (5) @(posedge clock);
    reset_n <= 1'h1;
    repeat (4) @(posedge clock);
    rd(disp_result_pkg::OFF_CONTROL);
    chk_word("control reset", 32'h40, q);
    rd(disp_result_pkg::OFF_OFFSET);
    chk_word("offset reset", 32'h0, q);
    rd(8'h24);
    chk_word("unmapped", 32'h1, {31'h0, err});
    ctl(32'h700);
    rd(disp_result_pkg::OFF_CONTROL);
    chk_word("one head", 32'h40, q);
    head2 <= 1'h1;
    repeat (4) @(posedge clock);
    for (m = 0; m < 4; m++) begin
      ctl(32'h400 | (m << 8));
      b = rnd();
      smp(rnd(), b);
      chk_word("combined", comb_exp(m, c1, b), v);
      chk_word("intensity", {16'h0, (m == 1) ? i2 : i1}, {16'h0, ri});
    end
    ctl(32'h400);
    for (m = 0; m < 4; m++) begin
      ctl(32'h4 | m);
      for (k = 0; k < 6; k++) step(m, k == 0);
      if (m != 0) begin
        ctl(32'h4 | m);
        step(m, 1'h1);
        cmd(disp_result_pkg::CMD_HOLD, 1'h0);
        cmd(disp_result_pkg::CMD_HOLD, 1'h0);
        step(m, 1'h1);
      end
    end
    ctl(32'h4);
    c1 <= 32'h64;
    cmd(disp_result_pkg::CMD_ZERO, 1'h1);
    smp(32'h82, 32'h0);
    chk_word("zeroed", 32'h1E, v);
    for (m = 0; m < 4; m++) begin
      ctl(32'h80 | (m << 4));
      #1;
      chk_word("fixed gain", m, {29'h0, gain_auto, gain_level});
    end
    ctl(32'hC0);
    i1 <= 16'h000A;
    repeat (4) smp(32'h0, 32'h0);
    la = gain_level;
    i1 <= 16'hAFC8;
    repeat (4) smp(32'h0, 32'h0);
    repeat (2) @(posedge clock);
    #1;
    chk_word("auto moved", 32'h1, {31'h0, la !== gain_level});
    la = gain_level;
    ctl(32'hC0);
    #1;
    chk_word("frozen gain", {30'h0, la}, {29'h0, gain_auto, gain_level});
    i1 <= 16'h03E8;
    cal(32'h5000, 1'h0);
    chk_word("rejected", 32'h40000000, q);
    chk_word("cal error", 32'h1, {31'h0, cal_error});
    cal(32'h4333, 1'h1);
    chk_word("abandoned", 32'h40000000, q);
    cal(32'h4333, 1'h0);
    chk_word("target cal", 32'h43330000, q);
    apb(1'h1, disp_result_pkg::OFF_COMMAND, 32'h40000080, 1'h0);
    rd(disp_result_pkg::OFF_CAL_FACT);
    chk_word("direct cal", 32'h40000000, q);
    ofs(32'h3E8, 1'h0);
    a = rnd();
    smp(a, 32'h0);
    chk_word("offset added", a + 32'h3E8, v);
    ofs(32'h5, 1'h1);
    rd(disp_result_pkg::OFF_OFFSET);
    chk_word("offset kept", 32'h3E8, q);
    ofs(32'h186A0, 1'h0);
    smp(32'hF94E, 32'h0);
    chk_word("span edge", 32'h27FEE, {v[31:1], v[0] | ro});
    smp(32'hF94F, 32'h0);
    chk_word("overflow", 32'h1, {31'h0, ro});
    complete_run();
  end
endmodule
